//--- design/eisw_cfg.svh
`ifndef EISW_CFG_SVH
`define EISW_CFG_SVH

// clock and timing
`define EISW_CLK_NS          10
`define EISW_OSC_SETTLE_NS   10000
`define EISW_OSC_SETTLE_CYC  \
  ((`EISW_OSC_SETTLE_NS + `EISW_CLK_NS - 1) / `EISW_CLK_NS)
`define EISW_WAKE_LOW_CYC    3

// interrupt pins and sources
`define EISW_NUM_PINS        5
`define EISW_NUM_SRC         7
`define EISW_SRC_RTC         5
`define EISW_SRC_USB         6
`define EISW_DETECT_PATTERN  5'h18

// register byte addresses
`define EISW_A_IRQ_EN        8'h00
`define EISW_A_IRQ_FLAG      8'h04
`define EISW_A_IDLE_CTRL     8'h08
`define EISW_A_BUS_SEL       8'h0c
`define EISW_A_STATUS        8'h10

// field positions
`define EISW_IDLE_CPU_BIT    0
`define EISW_IDLE_CLKGEN_BIT 1
`define EISW_BUS_HOST_BIT    0
`define EISW_BUS_HOST_PORT_IDLE_SEL_BIT    1

// reset values and responses
`define EISW_IRQ_EN_RST      7'h00
`define EISW_RESP_OKAY       2'h0
`define EISW_RESP_SLVERR     2'h2

`endif

//--- design/eisw_pkg.sv
package eisw_pkg;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_CPU_IDLE,
    ST_CLK_IDLE,
    ST_OSC_WAKE,
    ST_QUALIFY
  } eisw_state_type;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } eisw_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } eisw_axi_resp_type;

  typedef struct packed {
    logic rtc_irq;
    logic usb_event;
    logic pll_lock;
  } eisw_wake_in_type;

  typedef struct packed {
    logic [6:0] cpu_irq;
    logic       cpu_wake;
    logic       cpu_idle;
    logic       osc_enable;
    logic       usb_pll_enable;
    logic       clkgen_idle;
  } eisw_ctrl_out_type;

endpackage : eisw_pkg

//--- design/eisw_detect.sv
`include "eisw_cfg.svh"

module eisw_detect
  import eisw_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [4:0] irq_pin_n,
  output logic      [4:0] hit,
  output logic      [4:0] level_n
);

  typedef struct packed {
    logic [4:0]      s1;
    logic [4:0]      s2;
    logic [4:0][4:0] hist;
    logic [4:0]      hit;
  } eisw_det_type;

  eisw_det_type          r;
  eisw_det_type          next_r;
  logic [4:0][4:0]       next_hist;
  logic [4:0]            next_hit;

  // per pin history of synchronised samples, oldest in the top bit
  genvar g;
  generate
    for (g = 0; g < `EISW_NUM_PINS; g++)
    begin : g_pin
      assign next_hist[g] = {r.hist[g][3:0], r.s2[g]};
      assign next_hit[g]  = (next_hist[g] == `EISW_DETECT_PATTERN); // R3
    end
  endgenerate

  // two stage synchroniser, then pattern history
  always_comb
  begin
    next_r      = r;
    next_r.s1   = irq_pin_n;   // R1
    next_r.s2   = r.s1;        // R1
    next_r.hist = next_hist;
    next_r.hit  = next_hit;
  end

  // sampled on the falling clock edge; pins idle high after reset
  always_ff @(negedge aclk)    // R2
  begin
    if (!aresetn)
    begin
      r.s1   <= 5'h1f;
      r.s2   <= 5'h1f;
      r.hist <= '1;
      r.hit  <= 5'h00;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign hit     = r.hit;
  assign level_n = r.s2;

endmodule : eisw_detect

//--- design/eisw_top.sv
// Behaviour
// R1 - each active-low interrupt pin passes a two-flop synchroniser first.
// R2 - interrupt pins are sampled on the falling edge of the clock.
// R3 - an interrupt is detected only on samples 1-1-0-0-0 in a row.
// R4 - idle is left only on reset, pin interrupt, rtc or usb event.
// R5 - with the oscillator off a wake event restarts it and the usb pll.
// R6 - a disabled wake source restarts the clock but leaves the cpu idle.
// R7 - an enabled wake interrupt waits for settling and pll lock.
// R8 - a waking pin source must stay low 3 cycles after settling.
// R9 - a pin too short after settling wakes only the clock domain.
// R10 - software not using usb should idle the usb module after waking.
// R11 - the clock domain is not idled while in host port mode.
// R12 - host port idle select with the clkgen idle bit allows clock idle.
// R13 - each detection sets a pending flag, delivered only when enabled.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`include "eisw_cfg.svh"

module eisw_top
  import eisw_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire eisw_axi_req_type  axi_req,
  output eisw_axi_resp_type      axi_resp,
  input  wire logic [4:0]        irq_pin_n,
  input  wire eisw_wake_in_type  wake_in,
  output eisw_ctrl_out_type      ctrl_out
);

  // all state of the block in one record; write halves wait in their
  // aw_ and w_ fields until both are in, src remembers which events
  // opened an oscillator wake so that qualification knows what to
  // watch, cnt runs the settling time and low_cnt the pin hold time
  typedef struct packed {
    eisw_axi_resp_type axi;
    logic              aw_have;
    logic [7:0]        aw_addr;
    logic              w_have;
    logic [31:0]       w_data;
    logic              w_strb0;
    logic [6:0]        irq_enable_reg;
    logic [6:0]        pend;
    logic              clkgen_idle_bit;
    logic              enhanced_host_port_mode;
    logic              host_port_idle_sel;
    eisw_state_type    state;
    logic [6:0]        src;
    logic [9:0]        cnt;
    logic [1:0]        low_cnt;
    eisw_ctrl_out_type out;
  } eisw_top_type;

  // registered copy, its next value and the detector results
  eisw_top_type r;
  eisw_top_type next_r;
  logic [4:0]   pin_hit;
  logic [4:0]   pin_level_n;

  // pin synchronisers and pattern detectors
  // they run on the falling edge, so a hit reaches the rising edge half
  // a cycle later as a clean one-cycle event
  eisw_detect u_detect (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .irq_pin_n (irq_pin_n),
    .hit       (pin_hit),
    .level_n   (pin_level_n)
  );

  // bus slave, idle sequencer and interrupt delivery
  // decisions read the registered copy r; next_r carries what this
  // cycle has already changed, so later sections see earlier writes,
  // e.g. a clock idle bit written together with the idle request
  // already counts for that request
  always_comb
  begin
    logic [6:0] ev;
    logic [6:0] clr;
    logic       idle_go;
    logic       clk_allow;
    logic       pin_low;
    logic [7:0] ra;
    logic       ok;

    // defaults: nothing cleared, nothing requested
    ev        = {wake_in.usb_event, wake_in.rtc_irq, pin_hit};
    clr       = 7'h00;
    idle_go   = 1'b0;
    clk_allow = 1'b0;
    pin_low   = 1'b0;
    ra        = axi_req.araddr;
    ok        = 1'b1;
    next_r    = r;
    // wake is a one-cycle pulse
    next_r.out.cpu_wake = 1'b0;

    // write address and data are taken in either order
    // each half is parked until its partner arrives; its ready drops
    // meanwhile so a second address cannot overwrite the first
    if (axi_req.awvalid && r.axi.awready)
    begin
      next_r.aw_have = 1'b1;
      next_r.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && r.axi.wready)
    begin
      next_r.w_have  = 1'b1;
      next_r.w_data  = axi_req.wdata;
      next_r.w_strb0 = axi_req.wstrb[0];
    end

    // response stands until the master takes it
    if (r.axi.bvalid && axi_req.bready)
      next_r.axi.bvalid = 1'b0;

    // register write once both halves are held
    // held back while an old response still stands, so answers never
    // merge; a write without byte 0 strobed is answered but ignored
    if (r.aw_have && r.w_have && !r.axi.bvalid)
    begin
      next_r.aw_have    = 1'b0;
      next_r.w_have     = 1'b0;
      next_r.axi.bvalid = 1'b1;
      next_r.axi.bresp  = `EISW_RESP_OKAY;
      unique case (r.aw_addr)
        `EISW_A_IRQ_EN:
          if (r.w_strb0)
            next_r.irq_enable_reg = r.w_data[6:0];
        `EISW_A_IRQ_FLAG:
          if (r.w_strb0)
            clr = r.w_data[6:0];
        `EISW_A_IDLE_CTRL:
          if (r.w_strb0)
          begin
            next_r.clkgen_idle_bit = r.w_data[`EISW_IDLE_CLKGEN_BIT];
            idle_go = r.w_data[`EISW_IDLE_CPU_BIT];
          end
        `EISW_A_BUS_SEL:
          if (r.w_strb0)
          begin
            next_r.enhanced_host_port_mode =
              r.w_data[`EISW_BUS_HOST_BIT];
            next_r.host_port_idle_sel = r.w_data[`EISW_BUS_HOST_PORT_IDLE_SEL_BIT];
          end
        `EISW_A_STATUS: ;
        default:
          next_r.axi.bresp = `EISW_RESP_SLVERR;
      endcase
    end

    // pending flags: a new detection wins over a clear
    // a flag cleared by software in the very cycle its source fires
    // stays set, so no detection is lost to a software clear
    next_r.pend = (r.pend & ~clr) | ev;  // R13

    // idle sequencer
    // clock idle is allowed only with host port mode off or its idle
    // select set; otherwise the request falls back to cpu idle alone
    clk_allow = next_r.clkgen_idle_bit &&
                (!next_r.enhanced_host_port_mode ||
                 next_r.host_port_idle_sel);      // R11 R12
    // a pin that opened the wake and still reads low
    pin_low   = |(~pin_level_n & r.src[4:0]);
    unique case (r.state)
      // software asks for idle through the idle control register
      ST_RUN:
        if (idle_go)
          next_r.state = clk_allow ? ST_CLK_IDLE : ST_CPU_IDLE; // R11

      // oscillator still runs; any enabled pending flag wakes the cpu
      ST_CPU_IDLE:
        if ((next_r.pend & r.irq_enable_reg) != 7'h00)  // R4
        begin
          next_r.state        = ST_RUN;
          next_r.out.cpu_wake = 1'b1;
        end

      // oscillator stopped; every event restarts it, enabled or not
      ST_CLK_IDLE:
        if (ev != 7'h00)                    // R4 R5
        begin
          next_r.state = ST_OSC_WAKE;
          next_r.src   = ev;
          next_r.cnt   = 10'(`EISW_OSC_SETTLE_CYC);
        end

      // wait out the settling count and pll lock before delivery;
      // a disabled source leaves the cpu idle with the clock running
      ST_OSC_WAKE:
      begin
        // settling count runs down first
        if (r.cnt != 10'h000)
          next_r.cnt = r.cnt - 10'h001;
        if (r.cnt == 10'h000 && wake_in.pll_lock)   // R7
        begin
          if ((r.src & r.irq_enable_reg) == 7'h00)
            next_r.state = ST_CPU_IDLE;             // R6
          else if (r.src[`EISW_SRC_USB] || r.src[`EISW_SRC_RTC])
          begin
            next_r.state        = ST_RUN;
            next_r.out.cpu_wake = 1'b1;
          end
          else
          begin
            next_r.state   = ST_QUALIFY;
            next_r.low_cnt = 2'h0;
          end
        end
      end

      // a waking pin must stay low three more cycles, else only the
      // clock domain stays awake and that detection is dropped
      ST_QUALIFY:
        if (!pin_low)                               // R9
        begin
          next_r.state = ST_CPU_IDLE;
          next_r.pend  = next_r.pend & ~r.src;
        end
        else if (r.low_cnt == 2'(`EISW_WAKE_LOW_CYC - 1))  // R8
        begin
          next_r.state        = ST_RUN;
          next_r.out.cpu_wake = 1'b1;
        end
        else
          next_r.low_cnt = r.low_cnt + 2'h1;

      // an unused code falls back to run
      default:
        next_r.state = ST_RUN;
    endcase

    // outputs toward cpu and clock generator
    // taken from next_r so each output is a plain flop of the new
    // state; interrupts reach the cpu only while it runs
    next_r.out.cpu_idle    = (next_r.state != ST_RUN);
    next_r.out.clkgen_idle = (next_r.state == ST_CLK_IDLE);
    next_r.out.osc_enable  = (next_r.state != ST_CLK_IDLE);   // R5
    next_r.out.usb_pll_enable = (next_r.state != ST_CLK_IDLE);
    next_r.out.cpu_irq = (next_r.state == ST_RUN) ?
                         (next_r.pend & next_r.irq_enable_reg) :
                         7'h00;                                // R7 R13

    // read channel
    // the answer is built in the cycle the address is taken and then
    // stands untouched until rready; arready stays low meanwhile
    if (r.axi.rvalid && axi_req.rready)
      next_r.axi.rvalid = 1'b0;
    if (axi_req.arvalid && r.axi.arready)
    begin
      next_r.axi.rvalid = 1'b1;
      next_r.axi.rdata  = 32'h0000_0000;
      unique case (ra)
        `EISW_A_IRQ_EN:
          next_r.axi.rdata[6:0] = r.irq_enable_reg;
        `EISW_A_IRQ_FLAG:
          next_r.axi.rdata[6:0] = r.pend;
        `EISW_A_IDLE_CTRL:
          next_r.axi.rdata[`EISW_IDLE_CLKGEN_BIT] = r.clkgen_idle_bit;
        `EISW_A_BUS_SEL:
        begin
          next_r.axi.rdata[`EISW_BUS_HOST_BIT] =
            r.enhanced_host_port_mode;
          next_r.axi.rdata[`EISW_BUS_HOST_PORT_IDLE_SEL_BIT] = r.host_port_idle_sel;
        end
        `EISW_A_STATUS:
          next_r.axi.rdata[4:0] = {wake_in.pll_lock,
                                   r.out.osc_enable, r.state};
        default:
          ok = 1'b0;
      endcase
      // unmapped reads answer zero with an error
      next_r.axi.rresp = ok ? `EISW_RESP_OKAY : `EISW_RESP_SLVERR;
    end

    // ready flags follow the held state
    // computed last so they see every change made above
    next_r.axi.awready = !next_r.aw_have;
    next_r.axi.wready  = !next_r.w_have;
    next_r.axi.arready = !next_r.axi.rvalid;
  end

  // state register, synchronous reset
  // oscillator and pll start enabled so the part comes up running;
  // everything else, bus answers included, starts cleared and the
  // readies rise at the first edge after release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r                  <= '0;
      r.irq_enable_reg   <= `EISW_IRQ_EN_RST;
      r.state            <= ST_RUN;
      r.out.osc_enable   <= 1'b1;
      r.out.usb_pll_enable <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign axi_resp = r.axi;
  assign ctrl_out = r.out;

endmodule : eisw_top

//--- verif/eisw_asserts.sv
module eisw_asserts
  import eisw_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire eisw_axi_req_type  axi_req,
  input wire eisw_axi_resp_type axi_resp,
  input wire logic [4:0]        irq_pin_n,
  input wire eisw_wake_in_type  wake_in,
  input wire eisw_ctrl_out_type ctrl_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // set while a wake from a stopped oscillator is still on its way
  logic osc_wake_pending;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || ctrl_out.cpu_wake)
      osc_wake_pending <= 1'b0;
    else if (!ctrl_out.osc_enable)
      osc_wake_pending <= 1'b1;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // delivery and wake relations
  irq_gate_a: assert property (
    ctrl_out.cpu_irq != 7'h00 |-> !ctrl_out.cpu_idle)
    else $error("cpu irq raised while idle");
  wake_lock_a: assert property (
    ctrl_out.cpu_wake && osc_wake_pending |-> wake_in.pll_lock)
    else $error("cpu woken without pll lock");
  wake_cause_a: assert property (
    ctrl_out.cpu_wake |-> $past(ctrl_out.cpu_idle))
    else $error("wake pulse without prior idle");
  wake_pulse_a: assert property (
    ctrl_out.cpu_wake |=> !ctrl_out.cpu_wake)
    else $error("wake pulse longer than one cycle");
  idle_exit_a: assert property (
    $fell(ctrl_out.cpu_idle) |-> ctrl_out.cpu_wake)
    else $error("idle left without wake pulse");
  pll_follow_a: assert property (
    ctrl_out.usb_pll_enable == ctrl_out.osc_enable)
    else $error("pll enable differs from oscillator");
  osc_off_a: assert property (
    !ctrl_out.osc_enable |-> ctrl_out.clkgen_idle)
    else $error("oscillator off outside clock idle");
  // bus answers stand until taken
  bresp_hold_a: assert property (axi_resp.bvalid && !axi_req.bready
    |=> axi_resp.bvalid && $stable(axi_resp.bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (axi_resp.rvalid && !axi_req.rready
    |=> axi_resp.rvalid && $stable(axi_resp.rdata))
    else $error("read data dropped early");
  read_busy_a: assert property (axi_resp.rvalid |-> !axi_resp.arready)
    else $error("read accepted while answer pending");

  cover property (ctrl_out.cpu_wake);
  cover property (!ctrl_out.osc_enable);
  cover property (axi_resp.bvalid && axi_resp.bresp == 2'h2);
endmodule : eisw_asserts

bind eisw_top eisw_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .axi_req(axi_req), .axi_resp(axi_resp), .irq_pin_n(irq_pin_n),
  .wake_in(wake_in), .ctrl_out(ctrl_out));

//--- verif/eisw_src_model.sv
module eisw_src_model
  import eisw_pkg::*;
#(
  parameter int LOCK_CYC = 1200
)
(
  input  wire logic       aclk,
  input  wire logic       osc_enable,
  output logic [4:0]      irq_pin_n,
  output eisw_wake_in_type wake_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int lock_cnt = 0;

  // pins idle high by pull-up, pulses idle low
  initial
  begin
    irq_pin_n = 5'h1f;
    wake_in = '0;
  end

  // pll locks a while after the oscillator comes up
  always @(posedge aclk)
  begin
    if (!osc_enable)
      lock_cnt <= 0;
    else if (lock_cnt < LOCK_CYC)
      lock_cnt <= lock_cnt + 1;
    wake_in.pll_lock <= osc_enable && lock_cnt >= LOCK_CYC;
  end

  // pin low for n cycles, then released to the pull-up
  task pin_low(input int i, input int n);
    @(posedge aclk);
    irq_pin_n[i] <= 1'b0;
    repeat (n) @(posedge aclk);
    irq_pin_n[i] <= 1'b1;
  endtask : pin_low

  // pin held low until lock plus five cycles
  task pin_wake(input int i);
    @(posedge aclk);
    irq_pin_n[i] <= 1'b0;
    for (int k = 0; k < 3000 && !wake_in.pll_lock; k++) @(posedge aclk);
    repeat (5) @(posedge aclk);
    irq_pin_n[i] <= 1'b1;
  endtask : pin_wake

  // one-cycle rtc (0) or usb (1) event
  task pulse(input logic usb);
    @(posedge aclk);
    if (usb) wake_in.usb_event <= 1'b1;
    else wake_in.rtc_irq <= 1'b1;
    @(posedge aclk);
    wake_in.usb_event <= 1'b0;
    wake_in.rtc_irq <= 1'b0;
  endtask : pulse
endmodule : eisw_src_model

//--- verif/testbench.sv
`include "eisw_cfg.svh"

module testbench
  import eisw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OSC_B = 2, IDLE_B = 3, CLK_B = 0, PLL_B = 1;
  localparam logic [1:0] OK = `EISW_RESP_OKAY, ER = `EISW_RESP_SLVERR;
  logic              aclk = 1'b0;
  logic              aresetn;
  eisw_axi_req_type  axi_req;
  eisw_axi_resp_type axi_resp;
  logic [4:0]        irq_pin_n;
  eisw_wake_in_type  wake_in;
  eisw_ctrl_out_type ctrl_out;
  int                failures = 0;
  int                compares = 0;
  logic [3:0]        strb = 4'hf;

  // 100 MHz clock
  always #5 aclk = ~aclk;

  eisw_top dut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
    .axi_resp(axi_resp), .irq_pin_n(irq_pin_n), .wake_in(wake_in),
    .ctrl_out(ctrl_out));
  eisw_src_model src (.aclk(aclk), .osc_enable(ctrl_out.osc_enable),
    .irq_pin_n(irq_pin_n), .wake_in(wake_in));

  task final_report;
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // bus write, response checked
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= strb;
    axi_req.bready <= 1'b1;
    for (int i = 0; i < 64 && !done; i++)
    begin
      @(posedge aclk);
      if (axi_resp.awready) axi_req.awvalid <= 1'b0;
      if (axi_resp.wready) axi_req.wvalid <= 1'b0;
      if (axi_resp.bvalid)
      begin
        done = 1'b1;
        axi_req.bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, axi_resp.bresp});
      end
    end
    chk("bvalid", 32'h1, {31'h0, done});
    if (!done) final_report();
  endtask : wr

  // bus read, data and response checked
  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    for (int i = 0; i < 64 && !done; i++)
    begin
      @(posedge aclk);
      if (axi_resp.arready) axi_req.arvalid <= 1'b0;
      if (axi_resp.rvalid)
      begin
        done = 1'b1;
        axi_req.rready <= 1'b0;
        chk("rdata", ed, axi_resp.rdata);
        chk("rresp", {30'h0, er}, {30'h0, axi_resp.rresp});
      end
    end
    chk("rvalid", 32'h1, {31'h0, done});
    if (!done) final_report();
  endtask : rd

  // bounded wait for one control output bit
  task wt(input int k, input logic v, input int n);
    logic [11:0] cv;
    cv = ~{12{v}};
    for (int i = 0; i < n && cv[k] !== v; i++)
    begin
      @(posedge aclk);
      cv = ctrl_out;
    end
    chk("ctrl bit", {31'h0, v}, {31'h0, cv[k]});
    if (cv[k] !== v) final_report();
  endtask : wt

  // request clock idle and see the oscillator stop
  task idle_clk;
    wr(`EISW_A_IDLE_CTRL, 32'h3, OK);
    wt(OSC_B, 1'b0, 10);
  endtask : idle_clk

  initial
  begin
    axi_req = '0;
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`EISW_A_IRQ_EN, 32'h0, OK);
    rd(8'h14, 32'h0, ER);
    wr(8'h14, 32'h1, ER);
    // pulse detection and pending flags
    wr(`EISW_A_IRQ_EN, 32'hffff_ff7f, OK);
    // byte 0 not strobed: answered, no effect
    strb = 4'he;
    wr(`EISW_A_IRQ_EN, 32'h0, OK);
    strb = 4'hf;
    rd(`EISW_A_IRQ_EN, 32'h7f, OK);
    src.pin_low(2, 2);
    repeat (8) @(posedge aclk);
    rd(`EISW_A_IRQ_FLAG, 32'h0, OK);
    src.pin_low(1, 3);
    repeat (3) @(posedge aclk);
    rd(`EISW_A_IRQ_FLAG, 32'h2, OK);
    chk("cpu_irq", 32'h2, {25'h0, ctrl_out.cpu_irq});
    wr(`EISW_A_IRQ_FLAG, 32'h2, OK);
    rd(`EISW_A_IRQ_FLAG, 32'h0, OK);
    // disabled source restarts the clock only
    wr(`EISW_A_IRQ_EN, 32'h0, OK);
    idle_clk();
    wt(PLL_B, 1'b0, 2);
    src.pulse(1'b0);
    wt(OSC_B, 1'b1, 5);
    wt(PLL_B, 1'b1, 2);
    repeat (1300) @(posedge aclk);
    rd(`EISW_A_STATUS, 32'h19, OK);
    wr(`EISW_A_IRQ_EN, 32'h40, OK);
    src.pulse(1'b1);
    wt(IDLE_B, 1'b0, 20);
    wr(`EISW_A_IRQ_FLAG, 32'h7f, OK);
    // enabled source held back until pll lock
    wr(`EISW_A_IRQ_EN, 32'h7f, OK);
    idle_clk();
    src.pulse(1'b1);
    wt(OSC_B, 1'b1, 5);
    repeat (1100) @(posedge aclk);
    chk("cpu_idle", 32'h1, {31'h0, ctrl_out.cpu_idle});
    wt(IDLE_B, 1'b0, 300);
    wr(`EISW_A_IRQ_FLAG, 32'h7f, OK);
    // short pin wakes only the clock, a second one the cpu
    idle_clk();
    src.pin_low(0, 4);
    repeat (1500) @(posedge aclk);
    rd(`EISW_A_STATUS, 32'h19, OK);
    // a further interrupt on another pin wakes the cpu
    src.pin_low(4, 4);
    wt(IDLE_B, 1'b0, 40);
    wr(`EISW_A_IRQ_FLAG, 32'h7f, OK);
    idle_clk();
    src.pin_wake(3);
    wt(IDLE_B, 1'b0, 40);
    wr(`EISW_A_IRQ_FLAG, 32'h7f, OK);
    // host port mode refuses clock idle unless selected
    wr(`EISW_A_BUS_SEL, 32'h1, OK);
    wr(`EISW_A_IDLE_CTRL, 32'h3, OK);
    repeat (4) @(posedge aclk);
    rd(`EISW_A_STATUS, 32'h19, OK);
    src.pulse(1'b0);
    wt(IDLE_B, 1'b0, 20);
    wr(`EISW_A_BUS_SEL, 32'h3, OK);
    idle_clk();
    wt(CLK_B, 1'b1, 5);
    src.pulse(1'b1);
    wt(IDLE_B, 1'b0, 1500);
    // usb pll left running after the wake; idling it is up to software
    wt(PLL_B, 1'b1, 2);
    final_report();
  end
endmodule : testbench
